// [hdl/paac_defs.svh]
// constants for the port alarm and maintenance block
`ifndef PAAC_DEFS_SVH
`define PAAC_DEFS_SVH

// --------
// register byte offsets
// --------
`define PAAC_OFS_CTRL_ONE    8'h00
`define PAAC_OFS_CTRL_TWO    8'h04
`define PAAC_OFS_CTRL_THREE  8'h08
`define PAAC_OFS_CTRL_FOUR   8'h0c
`define PAAC_OFS_STATUS      8'h10

// --------
// reset values
// --------
`define PAAC_RST_LINE_ALARM  2'h0
`define PAAC_RST_PAY_ALARM   3'h0
`define PAAC_RST_FRAMING     3'h0
`define PAAC_RST_LOOPBACK    3'h0

// --------
// field codes
// --------
`define PAAC_LA_AUTO_DLB     2'h0
`define PAAC_LA_ALL_ONES     2'h1
`define PAAC_LA_ALARM        2'h2
`define PAAC_FM_G832         3'h3

// --------
// framed alarm geometry and timing
// --------
`define PAAC_BLOCK_BITS      7'h55
`define PAAC_BLOCKS          3'h7
`define PAAC_SUBFRAMES       3'h6
`define PAAC_ONES_RUN        12'h3ff
`define PAAC_CLK_PERIOD_NS   40
`define PAAC_OOF_PERSIST_NS  2500000

`endif

// [hdl/paac_pkg.sv]
// types for the port alarm and maintenance block
package paac_pkg;

    // control registers as software sees them
    typedef struct packed {
        logic       rx_alarm_sw;
        logic       bit_tester_enable;
        logic [2:0] payload_alarm_select;
        logic [1:0] line_alarm_select;
    } paac_ctrl_one_type;

    typedef struct packed {
        logic       rx_liu_enable;
        logic       unipolar_line_mode;
        logic [2:0] framing_mode_select;
    } paac_ctrl_two_type;

    // decoded loopback state
    typedef struct packed {
        logic line_loopback;
        logic payload_loopback;
        logic diagnostic_loopback;
    } paac_loop_type;

endpackage : paac_pkg

// [hdl/paac_port_alarm.sv]
// port level alarm, loopback steering and maintenance muxing
//
// How it works
// - unipolar line mode never reports signal loss
// - forwarded signal loss masked in diagnostic loopback
// - status signal loss valid, off when unipolar
// - alarm is framed DS3 or all ones
// - framed alarm: valid overhead, payload one-zero
// - port alarm switches cleanly on bit boundaries
// - port alarm keeps own frame alignment
// - port alarm runs in diag loop, not line loop
// - diagnostic loopback returns framer transmit data
// - detect framed alarm DS3 only, ones always
// - payload alarm replaces receive data, not looped
// - payload alarm enabled after reset
// - framer auto alarm waits in ds3 modes, port alarm immediate
// - no alarm detection on transmit path
// - receive alarm request sources and transmit starts
// - decode line alarm select field
// - decode payload alarm select field
// - loop timing takes receive clock
// - force HDLC receive data high on loss
// - trail trace granted only to G.832
// - bit tester replaces serial payload input in framing modes 0 to 3
`timescale 1ns/100ps
`include "paac_defs.svh"

module paac_port_alarm #(
    parameter int OOF_HOLD_CYCLES =
        (`PAAC_OOF_PERSIST_NS + `PAAC_CLK_PERIOD_NS - 1)
        / `PAAC_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // line side pins
    input  wire logic        tx_clock_input,
    input  wire logic        rx_line_clock_input,
    input  wire logic        rx_recovered_clock,
    input  wire logic        rx_line_data,
    output logic             tx_line_strobe,
    output logic             tx_line_data,
    // line decoder
    input  wire logic        decoder_signal_loss,
    // framer
    input  wire logic        framer_tx_data,
    input  wire logic        framer_rx_data,
    input  wire logic        out_of_frame,
    input  wire logic        frame_loss,
    input  wire logic        framer_ds3_alarm_seen,
    input  wire logic        framer_tx_data_enable,
    input  wire logic        framer_rx_data_enable,
    input  wire logic        framer_hdlc_data,
    output logic             framer_signal_loss,
    output logic             framer_auto_oof_alarm,
    output logic             framer_rx_alarm_request,
    output logic             framer_rx_line_data,
    output logic             framer_tx_payload,
    output logic             trail_trace_grant,
    output logic             hdlc_rx_data,
    // system payload and bit tester
    input  wire logic        tx_serial_payload_in,
    input  wire logic        bit_tester_tx_data,
    output logic             rx_serial_payload_out,
    output logic             bit_tester_rx_data,
    output logic             tx_data_enable,
    output logic             rx_data_enable
);
    import paac_pkg::*;

    // --------
    // registers
    // --------
    paac_ctrl_one_type ctrl_one;
    paac_ctrl_two_type ctrl_two;
    logic              loop_timing_enable;
    logic [2:0]        loopback_select;
    paac_loop_type     loop;
    logic [7:0]        read_addr;
    logic              write_go;
    logic              read_hit;
    logic [31:0]       status_word;

    assign write_go      = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = write_go;
    assign s_axi_wready  = write_go;
    assign s_axi_arready = ~s_axi_rvalid;

    // payload alarm select resets to 000 so downstream alarm starts on
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ctrl_one <= '{1'b0, 1'b0, `PAAC_RST_PAY_ALARM,
                          `PAAC_RST_LINE_ALARM};
            ctrl_two <= '{1'b0, 1'b0, `PAAC_RST_FRAMING};
            loop_timing_enable <= 1'b0;
            loopback_select    <= `PAAC_RST_LOOPBACK;
        end
        else if (write_go && s_axi_wstrb[0])
        begin
            unique case (s_axi_awaddr)
                `PAAC_OFS_CTRL_ONE:   ctrl_one <= s_axi_wdata[6:0];
                `PAAC_OFS_CTRL_TWO:   ctrl_two <= s_axi_wdata[4:0];
                `PAAC_OFS_CTRL_THREE: loop_timing_enable <= s_axi_wdata[0];
                `PAAC_OFS_CTRL_FOUR:  loopback_select <= s_axi_wdata[2:0];
                default: ;
            endcase
        end
    end

    // write response
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (write_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr == `PAAC_OFS_CTRL_ONE   ||
                             s_axi_awaddr == `PAAC_OFS_CTRL_TWO   ||
                             s_axi_awaddr == `PAAC_OFS_CTRL_THREE ||
                             s_axi_awaddr == `PAAC_OFS_CTRL_FOUR)
                            ? 2'h0 : 2'h2;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    assign read_addr = s_axi_araddr;
    assign read_hit  = (read_addr <= `PAAC_OFS_STATUS) &&
                       (read_addr[1:0] == 2'h0);

    // read response; status register is read only
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= read_hit ? 2'h0 : 2'h2;
            unique case (read_addr)
                `PAAC_OFS_CTRL_ONE:   s_axi_rdata <= {25'h0, ctrl_one};
                `PAAC_OFS_CTRL_TWO:   s_axi_rdata <= {27'h0, ctrl_two};
                `PAAC_OFS_CTRL_THREE: s_axi_rdata <= {31'h0,
                                                      loop_timing_enable};
                `PAAC_OFS_CTRL_FOUR:  s_axi_rdata <= {29'h0, loopback_select};
                `PAAC_OFS_STATUS:     s_axi_rdata <= status_word;
                default:              s_axi_rdata <= 32'h0;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // --------
    // pin synchronisers
    // --------
    logic [4:0] pin_raw;
    logic [4:0] sync_one;
    logic [4:0] sync_two;
    logic [4:0] sync_three;
    logic [4:0] pin_level;
    logic [4:0] pin_rise;

    assign pin_raw  = {tx_serial_payload_in, rx_line_data,
                       rx_recovered_clock, rx_line_clock_input,
                       tx_clock_input};
    assign pin_rise = sync_two & sync_three & ~pin_level;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sync_one   <= 5'h0;
            sync_two   <= 5'h0;
            sync_three <= 5'h0;
            pin_level  <= 5'h0;
        end
        else
        begin
            sync_one   <= pin_raw;
            sync_two   <= sync_one;
            sync_three <= sync_two;
            pin_level  <= (sync_two & sync_three) |
                          (pin_level & (sync_two | sync_three));
        end
    end

    // --------
    // clock selection and loopback decode
    // --------
    logic rx_strobe;
    logic tx_strobe;
    logic ds3_mode;
    logic ds3_framed;

    assign rx_strobe = ctrl_two.rx_liu_enable ? pin_rise[2] : pin_rise[1];
    assign tx_strobe = loop_timing_enable ? rx_strobe
                                          : pin_rise[0];
    assign ds3_mode   = ~ctrl_two.framing_mode_select[1];
    assign ds3_framed = ds3_mode & ~ctrl_two.framing_mode_select[2];

    always_comb
    begin
        loop.diagnostic_loopback = loopback_select[2];
        loop.line_loopback       = loopback_select[1] & ~loopback_select[0];
        loop.payload_loopback    = (loopback_select == 3'h3);
    end

    // --------
    // signal loss and alarm requests
    // --------
    logic        signal_loss;
    logic        oof_held;
    logic [31:0] oof_count;
    logic        rx_all_ones;
    logic [11:0] ones_run;

    assign signal_loss = decoder_signal_loss &
                         ~ctrl_two.unipolar_line_mode;
    assign framer_signal_loss = signal_loss &
                                ~loop.diagnostic_loopback;

    // framer auto alarm waits for out of frame to persist in ds3 modes
    always_ff @(posedge ref_clk)
    begin
        if (reset || !out_of_frame)
            oof_count <= 32'h0;
        else if (!oof_held)
            oof_count <= oof_count + 32'h1;
    end
    assign oof_held = (oof_count >= 32'(OOF_HOLD_CYCLES));
    assign framer_auto_oof_alarm = out_of_frame &
                                   (oof_held | ~ds3_mode);

    // unframed all ones seen on the receive data feeding the framer
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ones_run <= 12'h0;
        else if (rx_strobe)
        begin
            if (!framer_rx_line_data)
                ones_run <= 12'h0;
            else if (!rx_all_ones)
                ones_run <= ones_run + 12'h1;
        end
    end
    assign rx_all_ones = (ones_run == `PAAC_ONES_RUN);

    // framed alarm detection is meaningful only in ds3 modes
    logic alarm_seen;
    assign alarm_seen = rx_all_ones |
                        (framer_ds3_alarm_seen & ds3_mode);

    assign framer_rx_alarm_request = ctrl_one.rx_alarm_sw | alarm_seen |
                                     framer_signal_loss |
                                     framer_auto_oof_alarm;

    // --------
    // payload (downstream) alarm
    // --------
    logic llb_only;
    logic payload_alarm;

    assign llb_only = loop.line_loopback & ~loop.diagnostic_loopback;

    always_comb
    begin
        unique case (ctrl_one.payload_alarm_select)
            3'h0: payload_alarm = 1'b1;
            3'h1: payload_alarm = llb_only;
            3'h2: payload_alarm = loop.payload_loopback;
            3'h3: payload_alarm = llb_only | loop.payload_loopback;
            3'h4: payload_alarm = framer_signal_loss;
            3'h5: payload_alarm = out_of_frame;
            3'h6: payload_alarm = out_of_frame | framer_signal_loss |
                                  llb_only | loop.payload_loopback;
            3'h7: payload_alarm = 1'b0;
        endcase
    end

    // port alarm goes downstream only; loopback uses framer payload
    assign rx_serial_payload_out = payload_alarm | framer_rx_data;
    assign bit_tester_rx_data    = payload_alarm | framer_rx_data;
    assign rx_data_enable        = framer_rx_data_enable;
    assign hdlc_rx_data = framer_hdlc_data | frame_loss |
                          alarm_seen;
    assign trail_trace_grant = (ctrl_two.framing_mode_select ==
                                `PAAC_FM_G832);

    // --------
    // transmit payload: no pattern checks on this path
    // --------
    assign tx_data_enable = framer_tx_data_enable;
    always_comb
    begin
        if (loop.payload_loopback)
            framer_tx_payload = framer_rx_data;
        else if (ctrl_one.bit_tester_enable &&
                 !ctrl_two.framing_mode_select[2])
            framer_tx_payload = bit_tester_tx_data;
        else
            framer_tx_payload = pin_level[4];
    end

    // diagnostic loopback hands framer output, port alarm excluded, back
    assign framer_rx_line_data = loop.diagnostic_loopback
                                 ? framer_tx_data
                                 : pin_level[3];

    // --------
    // port level line alarm
    // --------
    logic line_alarm;
    logic line_framed;

    always_comb
    begin
        unique case (ctrl_one.line_alarm_select)
            `PAAC_LA_AUTO_DLB: line_alarm = loop.diagnostic_loopback;
            `PAAC_LA_ALL_ONES: line_alarm = 1'b1;
            `PAAC_LA_ALARM:    line_alarm = 1'b1;
            default:           line_alarm = 1'b0;
        endcase
        line_framed = ds3_mode &&
                      ctrl_one.line_alarm_select != `PAAC_LA_ALL_ONES;
    end

    // framed generator free-runs on its own count so a framer slip
    // never moves its alignment once started
    logic [6:0] bit_pos;
    logic [2:0] block_pos;
    logic [2:0] sub_pos;
    logic       parity_run;
    logic       parity_last;
    logic       framed_bit;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            bit_pos     <= 7'h0;
            block_pos   <= 3'h0;
            sub_pos     <= 3'h0;
            parity_run  <= 1'b0;
            parity_last <= 1'b0;
        end
        else if (tx_strobe)
        begin
            if (bit_pos != 7'h0)
                parity_run <= parity_run ^ framed_bit;
            if (bit_pos == `PAAC_BLOCK_BITS - 7'h1)
            begin
                bit_pos <= 7'h0;
                if (block_pos == `PAAC_BLOCKS)
                begin
                    block_pos <= 3'h0;
                    if (sub_pos == `PAAC_SUBFRAMES)
                    begin
                        sub_pos     <= 3'h0;
                        parity_last <= parity_run ^ framed_bit;
                        parity_run  <= 1'b0;
                    end
                    else
                        sub_pos <= sub_pos + 3'h1;
                end
                else
                    block_pos <= block_pos + 3'h1;
            end
            else
                bit_pos <= bit_pos + 7'h1;
        end
    end

    // overhead order per subframe: lead, F1, C1, F2, C2, F3, C3, F4
    always_comb
    begin
        if (bit_pos != 7'h0)
            framed_bit = bit_pos[0];
        else
        begin
            unique case (block_pos)
                3'h0:
                begin
                    if (sub_pos < 3'h2)
                        framed_bit = 1'b1;
                    else if (sub_pos < 3'h4)
                        framed_bit = parity_last;
                    else
                        framed_bit = (sub_pos == 3'h5);
                end
                3'h1, 3'h7: framed_bit = 1'b1;
                default:    framed_bit = 1'b0;
            endcase
        end
    end

    // line output: binary data before the encoder, changed only on
    // a bit strobe, so no bipolar violation can be made here
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tx_line_data <= 1'b0;
        else if (loop.line_loopback && rx_strobe)
            tx_line_data <= pin_level[3];
        else if (!loop.line_loopback && tx_strobe)
        begin
            if (line_alarm)
                tx_line_data <= line_framed ? framed_bit
                                            : 1'b1;
            else
                tx_line_data <= framer_tx_data;
        end
    end

    // the clean start sequence is software's job with auto modes off
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            tx_line_strobe <= 1'b0;
        else
            tx_line_strobe <= loop.line_loopback ? rx_strobe
                                                 : tx_strobe;
    end

    // --------
    // status word
    // --------
    assign status_word = {26'h0, trail_trace_grant, oof_held,
                          rx_all_ones, payload_alarm,
                          line_alarm & ~loop.line_loopback,
                          signal_loss};

endmodule : paac_port_alarm

// [verif/paac_line_model.sv]
// line side partner: link clocks, receive line data, transmit bit counts
`timescale 1ns/100ps
module paac_line_model (
    // bench controls
    input  wire logic ref_clk,
    input  wire logic tx_run,
    input  wire logic rx_run,
    input  wire logic rx_ones,
    // line pins
    input  wire logic tx_line_strobe,
    input  wire logic tx_line_data,
    output logic      tx_clock_input,
    output logic      rx_line_clock_input,
    output logic      rx_line_data,
    // transmit bits seen and how many were ones
    output int        bits_seen,
    output int        ones_seen
);
    // each clock stands low while its run input is low
    initial
    begin
        tx_clock_input = 1'b0;
        forever #160 tx_clock_input = tx_run & !tx_clock_input;
    end
    initial
    begin
        rx_line_clock_input = 1'b0;
        rx_line_data = 1'b0;
        #7;
        forever #160 rx_line_clock_input = rx_run & !rx_line_clock_input;
    end
    // no pull on the line, so idle data toggles rather than holding
    always @(posedge rx_line_clock_input)
        rx_line_data <= rx_ones | !rx_line_data;
    initial
        {bits_seen, ones_seen} = '0;
    always @(posedge ref_clk)
        if (tx_line_strobe)
        begin
            bits_seen <= bits_seen + 1;
            ones_seen <= ones_seen + tx_line_data;
        end
endmodule : paac_line_model

// [verif/paac_port_alarm_bench.sv]
// self-checking bench for the port alarm block
`timescale 1ns/100ps
`include "paac_defs.svh"
module paac_port_alarm_bench;
    logic        ref_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, rx_ones;
    logic        tx_clock_input, rx_line_clock_input, rx_line_data;
    logic        rx_recovered_clock, tx_line_strobe, tx_line_data, tx_run;
    logic        decoder_signal_loss, framer_tx_data, framer_rx_data, rx_run;
    logic        out_of_frame, frame_loss, framer_ds3_alarm_seen;
    logic        framer_tx_data_enable, framer_rx_data_enable;
    logic        framer_hdlc_data, framer_signal_loss, framer_auto_oof_alarm;
    logic        framer_rx_alarm_request, framer_rx_line_data;
    logic        framer_tx_payload, trail_trace_grant, hdlc_rx_data;
    logic        tx_serial_payload_in, bit_tester_tx_data, tx_data_enable;
    logic        rx_serial_payload_out, bit_tester_rx_data, rx_data_enable;
    int          bits_seen, ones_seen, b, o, failures, total_checks;

    paac_port_alarm #(.OOF_HOLD_CYCLES(20)) dut_u (.*);
    paac_line_model line_u (.*);

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = !ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        @(posedge ref_clk);
        while (!s_axi_awready) @(posedge ref_clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        @(posedge ref_clk);
        while (!s_axi_bvalid) @(posedge ref_clk);
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        @(posedge ref_clk);
        while (!s_axi_arready) @(posedge ref_clk);
        s_axi_arvalid <= 1'b0;
        @(posedge ref_clk);
        while (!s_axi_rvalid) @(posedge ref_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rd

    // settle, then count line bits over fifty link periods
    task automatic meas;
        repeat (40) @(posedge ref_clk);
        b = bits_seen;
        o = ones_seen;
        repeat (400) @(posedge ref_clk);
        b = bits_seen - b;
        o = ones_seen - o;
    endtask : meas

    task automatic t_loss;
        rd(`PAAC_OFS_CTRL_ONE);
        chk(d, 32'h0);
        chk(rx_serial_payload_out, 1'b1);
        rd(8'h14);
        chk(r, 2'h2);
        decoder_signal_loss <= 1'b1;
        framer_tx_data <= 1'b1;
        wr(`PAAC_OFS_CTRL_TWO, 32'h8);
        chk(framer_signal_loss, 1'b0);
        rd(`PAAC_OFS_STATUS);
        chk(d[0], 1'b0);
        wr(`PAAC_OFS_CTRL_TWO, 32'h0);
        chk(framer_signal_loss, 1'b1);
        wr(`PAAC_OFS_CTRL_FOUR, 32'h4);
        chk(framer_signal_loss, 1'b0);
        chk(framer_rx_line_data, 1'b1);
        rd(`PAAC_OFS_STATUS);
        chk(d[0], 1'b1);
        framer_tx_data <= 1'b0;
    endtask : t_loss

    // pass 0: loss only; pass 1: line loopback only
    task automatic t_pay;
        for (int m = 0; m < 2; m++)
        begin
            decoder_signal_loss <= !m;
            wr(`PAAC_OFS_CTRL_FOUR, m * 2);
            for (int i = 0; i < 8; i++)
            begin
                wr(`PAAC_OFS_CTRL_ONE, (i << 2) | 3);
                chk(rx_serial_payload_out,
                    m ? i inside {0, 1, 3, 6} : i inside {0, 4, 6});
            end
        end
        wr(`PAAC_OFS_CTRL_FOUR, 32'h0);
    endtask : t_pay

    task automatic t_oof;
        wr(`PAAC_OFS_CTRL_ONE, 32'h17);
        out_of_frame <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk(framer_auto_oof_alarm, 1'b0);
        chk(rx_serial_payload_out, 1'b1);
        repeat (25) @(posedge ref_clk);
        chk(framer_auto_oof_alarm, 1'b1);
        chk(framer_rx_alarm_request, 1'b1);
        out_of_frame <= 1'b0;
        wr(`PAAC_OFS_CTRL_TWO, 32'h2);
        out_of_frame <= 1'b1;
        @(posedge ref_clk);
        chk(framer_auto_oof_alarm, 1'b1);
        out_of_frame <= 1'b0;
    endtask : t_oof

    task automatic t_mux;
        for (int i = 0; i < 8; i++)
        begin
            wr(`PAAC_OFS_CTRL_TWO, i);
            chk(trail_trace_grant, i == 3);
        end
        bit_tester_tx_data <= 1'b1;
        frame_loss <= 1'b1;
        wr(`PAAC_OFS_CTRL_TWO, 32'h0);
        chk(hdlc_rx_data, 1'b1);
        wr(`PAAC_OFS_CTRL_ONE, 32'h23);
        chk(framer_tx_payload, 1'b1);
        wr(`PAAC_OFS_CTRL_FOUR, 32'h3);
        chk(framer_tx_payload, 1'b0);
        wr(`PAAC_OFS_CTRL_FOUR, 32'h0);
        wr(`PAAC_OFS_CTRL_TWO, 32'h4);
        chk(framer_tx_payload, 1'b0);
        frame_loss <= 1'b0;
        framer_ds3_alarm_seen <= 1'b1;
        wr(`PAAC_OFS_CTRL_FOUR, 32'h0);
        framer_ds3_alarm_seen <= 1'b0;
        wr(`PAAC_OFS_CTRL_TWO, 32'h0);
    endtask : t_mux

    task automatic t_line;
        tx_run <= 1'b1;
        for (int la = 0; la < 4; la++)
        begin
            wr(`PAAC_OFS_CTRL_ONE, 32'h1c | la);
            meas;
            chk(b > 40, 1'b1);
            chk(la == 1 ? o == b : la == 2 ? o > b / 3 && o < 2 * b / 3
                : o == 0, 1'b1);
        end
        wr(`PAAC_OFS_CTRL_ONE, 32'h1c);
        wr(`PAAC_OFS_CTRL_FOUR, 32'h4);
        meas;
        chk(o > b / 3 && o < 2 * b / 3, 1'b1);
        rx_run <= 1'b1;
        wr(`PAAC_OFS_CTRL_ONE, 32'h1d);
        wr(`PAAC_OFS_CTRL_FOUR, 32'h2);
        meas;
        chk(b > 40 && o < b, 1'b1);
        tx_run <= 1'b0;
        wr(`PAAC_OFS_CTRL_FOUR, 32'h0);
        wr(8'h08, 32'h1);
        meas;
        chk(b > 40 && o == b, 1'b1);
    endtask : t_line

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // the run needs about thirty-three hundred cycles
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        test_done;
    end

    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {rx_recovered_clock, decoder_signal_loss, framer_tx_data} = '0;
        {framer_rx_data, out_of_frame, frame_loss, framer_hdlc_data} = '0;
        {framer_ds3_alarm_seen, tx_serial_payload_in} = '0;
        {bit_tester_tx_data, tx_run, rx_run, rx_ones} = '0;
        {failures, total_checks} = '0;
        {framer_tx_data_enable, framer_rx_data_enable} = 2'h3;
        s_axi_wstrb = 4'hf;
        reset = 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_loss;
        t_pay;
        t_oof;
        t_mux;
        t_line;
        test_done;
    end
endmodule : paac_port_alarm_bench

// [verif/paac_port_alarm_sva.sv]
// assertion checker for the port alarm block
`timescale 1ns/100ps
module paac_port_alarm_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // watched pins
    input wire logic decoder_signal_loss,
    input wire logic framer_signal_loss,
    input wire logic framer_rx_alarm_request,
    input wire logic frame_loss,
    input wire logic framer_ds3_alarm_seen,
    input wire logic hdlc_rx_data,
    input wire logic framer_rx_data,
    input wire logic rx_serial_payload_out,
    input wire logic bit_tester_rx_data,
    input wire logic framer_tx_data_enable,
    input wire logic tx_data_enable,
    input wire logic tx_line_strobe,
    input wire logic tx_line_data
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    loss_fwd_a: assert property (framer_signal_loss |-> decoder_signal_loss)
        else $error("forwarded loss without decoder loss");
    loss_req_a: assert property (framer_signal_loss |-> framer_rx_alarm_request)
        else $error("loss did not request receive alarm");
    hdlc_force_a: assert property ((frame_loss || framer_ds3_alarm_seen) |-> hdlc_rx_data)
        else $error("hdlc data not forced high");
    pay_ones_a: assert property (framer_rx_data |-> rx_serial_payload_out)
        else $error("receive payload lost a one");
    tester_copy_a: assert property (bit_tester_rx_data == rx_serial_payload_out)
        else $error("tester and serial payload differ");
    tx_enable_a: assert property (tx_data_enable == framer_tx_data_enable)
        else $error("transmit enable not passed through");
    strobe_pulse_a: assert property (tx_line_strobe |=> !tx_line_strobe)
        else $error("line strobe longer than one cycle");
    line_hold_a: assert property (!$stable(tx_line_data) |-> tx_line_strobe)
        else $error("line bit changed without strobe");
endmodule : paac_port_alarm_sva

bind paac_port_alarm paac_port_alarm_sva sva_u (.*);
